// >>> hdl/adc_flag_pkg.sv
// constants for the converter status-flag block: register map, field positions,
// reset values and default sizes. assumes 32-bit register words on a plain port.
package adc_flag_pkg;

  // sizes
  localparam int ADDR_W        = 8;
  localparam int DATA_W        = 32;
  localparam int NUM_CH_DEF    = 8;
  localparam int RES_W_DEF     = 10;
  localparam int STAT_FIELD_W  = 8;

  // register byte offsets
  localparam logic [ADDR_W-1:0] OFS_CTRL   = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_MODE   = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_CHEN   = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_CHDIS  = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_CHSR   = 8'h18;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h1c;
  localparam logic [ADDR_W-1:0] OFS_LAST   = 8'h20;
  localparam logic [ADDR_W-1:0] OFS_MASK   = 8'h2c;
  localparam logic [ADDR_W-1:0] OFS_CDR0   = 8'h30;

  // field positions
  localparam int CTRL_START_BIT = 1;
  localparam int MODE_TRIG_BIT  = 0;
  localparam int MODE_SLEEP_BIT = 5;
  localparam int STAT_EOC_LSB   = 0;
  localparam int STAT_CHANNEL_OVERRUN_FLAG_LSB  = 8;
  localparam int STAT_RESULT_READY_FLAG_BIT  = 16;
  localparam int STAT_GLOBAL_OVERRUN_FLAG_BIT = 17;
  localparam int LAST_CH_LSB    = 12;

  // reset values
  localparam logic [DATA_W-1:0] RST_WORD = 32'h0000_0000;
  localparam logic              RST_BIT  = 1'b0;

endpackage : adc_flag_pkg

// >>> hdl/adc_status_flag_logic.sv
// converter sequencer with result registers and status flags on a plain register port.
// assumes the analog core runs on mclk_i and answers each start with one done pulse.
//
// The address map and the address-and-strobe port were decided locally.
`timescale 1ns/1ps

// What this block does
// RULE1: result_ready_flag is cleared only by a read of last_result_reg, never by a channel_result_reg read.
// RULE2: a stored result on an enabled channel writes both result registers and raises result_ready_flag, whatever channel is disabled meanwhile.
// RULE3: a conversion whose result is not stored never raises result_ready_flag, even beside a last_result_reg read.
// RULE4: a channel_result_reg read of one channel does not stop result_ready_flag rising for another channel's stored result.
// RULE5: a stored result while result_ready_flag is already set raises global_overrun_flag.
// RULE6: a status read clears global_overrun_flag unless a new global overrun happens in that cycle, which sets it.
// RULE7: global_overrun_flag still sets when another channel's channel_result_reg is read in the same cycle.
// RULE8: a stored result on a channel whose end flag is still set raises its channel_overrun_flag, whatever is disabled meanwhile.
// RULE9: reading a channel_result_reg or last_result_reg clears the end flag of the channel whose data is read.
// RULE10: a status read clears a set channel_overrun_flag unless that channel's end flag sets in the same cycle while already set, which sets it.
// RULE11: a channel disabled during its own conversion never gets its end flag raised.
// RULE12: a channel_result_reg read clears only that channel's end flag, even beside another channel's end of conversion.
// RULE13: sleep enabled while idle takes effect only when the next conversion sequence completes.
// RULE14: software should set the sleep bit and then issue start to sleep promptly after that conversion.
// RULE15: reset clears result_ready_flag, global_overrun_flag and every end and overrun flag.
module adc_status_flag_logic #(
  parameter int NCH   = adc_flag_pkg::NUM_CH_DEF,
  parameter int RES_W = adc_flag_pkg::RES_W_DEF,
  parameter int CH_W  = $clog2(adc_flag_pkg::NUM_CH_DEF)
) (
  // clock and reset
  input  wire logic                              mclk_i,
  input  wire logic                              rst_b_i,
  // register port
  input  wire logic [adc_flag_pkg::ADDR_W-1:0]   addr_i,
  input  wire logic [adc_flag_pkg::DATA_W-1:0]   wdata_i,
  input  wire logic                              wr_i,
  input  wire logic                              rd_i,
  output logic      [adc_flag_pkg::DATA_W-1:0]   rdata_o,
  output logic                                   irq_o,
  // analog core
  output logic                                   core_start_o,
  output logic      [CH_W-1:0]                   core_chan_o,
  input  wire logic                              core_done_i,
  input  wire logic [RES_W-1:0]                  core_result_i,
  // pins and power
  input  wire logic                              ext_trig_i,
  output logic                                   sleep_o
);
  import adc_flag_pkg::*;

  typedef enum logic {ST_IDLE, ST_CONV} seq_e;

  // lowest enabled channel at or above a start index; msb says one was found
  function automatic logic [CH_W:0] next_chan(input logic [NCH-1:0] en, input int from);
    logic [CH_W:0] r;
    r = '0;
    for (int j = NCH - 1; j >= 0; j--) begin
      if (en[j] && (j >= from)) begin
        r = {1'b1, CH_W'(j)};
      end
    end
    return r;
  endfunction : next_chan

  // state
  seq_e                state_q;
  logic [CH_W-1:0]     cur_q;
  logic                dead_q;
  logic                mode_trig_q;
  logic                mode_sleep_q;
  logic [NCH-1:0]      chen_q;
  logic [DATA_W-1:0]   mask_q;
  logic [NCH-1:0]      eoc_q;
  logic [NCH-1:0]      channel_overrun_flag_q;
  logic                result_ready_flag_q;
  logic                global_overrun_flag_q;
  logic [RES_W-1:0]    last_res_q;
  logic [CH_W-1:0]     last_ch_q;
  logic [RES_W-1:0]    cdr_q [NCH];
  logic                trig_s1_q;
  logic                trig_s2_q;
  logic                trig_s3_q;

  // register decode
  wire                 wr_ctrl   = wr_i && (addr_i == OFS_CTRL);
  wire                 wr_mode   = wr_i && (addr_i == OFS_MODE);
  wire                 wr_chen   = wr_i && (addr_i == OFS_CHEN);
  wire                 wr_chdis  = wr_i && (addr_i == OFS_CHDIS);
  wire                 wr_mask   = wr_i && (addr_i == OFS_MASK);
  wire                 rd_mode   = rd_i && (addr_i == OFS_MODE);
  wire                 rd_chsr   = rd_i && (addr_i == OFS_CHSR);
  wire                 rd_sr     = rd_i && (addr_i == OFS_STATUS);
  wire                 rd_last   = rd_i && (addr_i == OFS_LAST);
  wire                 rd_mask   = rd_i && (addr_i == OFS_MASK);
  wire [ADDR_W-1:0]    cdr_off   = addr_i - OFS_CDR0;
  wire                 cdr_range = (addr_i >= OFS_CDR0) && (cdr_off[1:0] == 2'b00)
                                   && (int'(cdr_off[ADDR_W-1:2]) < NCH);
  wire                 rd_cdr    = rd_i && cdr_range;
  wire [CH_W-1:0]      cdr_idx   = cdr_off[CH_W+1:2];

  // sequencing
  wire                 start_cmd = wr_ctrl && wdata_i[CTRL_START_BIT];
  // only the second sync flop feeds the edge detector
  wire                 trig_edge = mode_trig_q && trig_s2_q && !trig_s3_q;
  wire                 go        = (start_cmd || trig_edge) && (state_q == ST_IDLE);
  wire [CH_W:0]        first_ch  = next_chan(chen_q, 0);
  wire [CH_W:0]        next_ch   = next_chan(chen_q, int'(cur_q) + 1);
  wire                 done_ok   = (state_q == ST_CONV) && core_done_i;
  // disabled mid-conversion: result dropped, no flag [RULE3] [RULE11]
  wire                 store     = done_ok && !dead_q && chen_q[cur_q];
  wire                 seq_end   = done_ok && !next_ch[CH_W];

  // flag next values; sets always win over clears
  logic [NCH-1:0]      eoc_set;
  logic [NCH-1:0]      eoc_clr;
  logic [NCH-1:0]      channel_overrun_flag_set;
  for (genvar i = 0; i < NCH; i++) begin : g_ch
    assign eoc_set[i]  = store && (cur_q == CH_W'(i));                     // [RULE2]
    assign eoc_clr[i]  = (rd_cdr && (cdr_idx == CH_W'(i)))                // [RULE9] [RULE12]
                         || (rd_last && (last_ch_q == CH_W'(i)));          // [RULE9]
    assign channel_overrun_flag_set[i] = eoc_set[i] && eoc_q[i];                           // [RULE8]
  end
  wire [NCH-1:0]       eoc_d   = eoc_set | (eoc_q & ~eoc_clr);
  wire [NCH-1:0]       channel_overrun_flag_d  = channel_overrun_flag_set | (channel_overrun_flag_q & {NCH{!rd_sr}});      // [RULE10]
  wire                 result_ready_flag_d  = store || (result_ready_flag_q && !rd_last);            // [RULE1] [RULE4]
  wire                 gov_set = store && result_ready_flag_q;                          // [RULE5] [RULE7]
  wire                 global_overrun_flag_d = gov_set || (global_overrun_flag_q && !rd_sr);           // [RULE6]

  // read selection
  wire [DATA_W-1:0]    stat_w  = {14'h0000, global_overrun_flag_q, result_ready_flag_q,
                                  STAT_FIELD_W'(channel_overrun_flag_q), STAT_FIELD_W'(eoc_q)};
  wire [DATA_W-1:0]    last_w  = DATA_W'({last_ch_q, (LAST_CH_LSB)'(last_res_q)});
  wire [DATA_W-1:0]    mode_w  = DATA_W'({mode_sleep_q, 4'h0, mode_trig_q});
  wire [DATA_W-1:0]    rdata_d = rd_sr   ? stat_w :
                                 rd_last ? last_w :
                                 rd_cdr  ? DATA_W'(cdr_q[cdr_idx]) :
                                 rd_mode ? mode_w :
                                 rd_chsr ? DATA_W'(chen_q) :
                                 rd_mask ? mask_q : RST_WORD;
  wire                 irq_d   = |(stat_w & mask_q);

  // trigger pin synchroniser; the pin is asynchronous to mclk_i
  always_ff @(posedge mclk_i) begin
    if (!rst_b_i) begin
      trig_s1_q <= RST_BIT;
      trig_s2_q <= RST_BIT;
    end else begin
      trig_s1_q <= ext_trig_i;
      trig_s2_q <= trig_s1_q;
    end
  end

  // delayed copy for the edge detector; resets low like the idle pin, so no false edge
  always_ff @(posedge mclk_i) begin
    if (!rst_b_i) begin
      trig_s3_q <= RST_BIT;
    end else begin
      trig_s3_q <= trig_s2_q;
    end
  end

  // trigger enable bit
  always_ff @(posedge mclk_i) begin
    if (!rst_b_i) begin
      mode_trig_q <= RST_BIT;
    end else if (wr_mode) begin
      mode_trig_q <= wdata_i[MODE_TRIG_BIT];
    end
  end

  // sleep request bit; only looked at when a sequence ends
  always_ff @(posedge mclk_i) begin
    if (!rst_b_i) begin
      mode_sleep_q <= RST_BIT;
    end else if (wr_mode) begin
      mode_sleep_q <= wdata_i[MODE_SLEEP_BIT];                             // [RULE13]
    end
  end

  // channel enables: a bit set and cleared in one cycle ends up cleared
  wire [NCH-1:0]       chen_d = (chen_q | ({NCH{wr_chen}} & wdata_i[NCH-1:0]))
                                & ~({NCH{wr_chdis}} & wdata_i[NCH-1:0]);
  always_ff @(posedge mclk_i) begin
    if (!rst_b_i) begin
      chen_q <= '0;
    end else begin
      chen_q <= chen_d;
    end
  end

  // interrupt mask, status layout
  always_ff @(posedge mclk_i) begin
    if (!rst_b_i) begin
      mask_q <= RST_WORD;
    end else if (wr_mask) begin
      mask_q <= wdata_i;
    end
  end

  // conversion sequencer
  wire                 kill_cur = (state_q == ST_CONV) && wr_chdis && wdata_i[cur_q];
  wire                 launch   = go && first_ch[CH_W];
  wire                 advance  = done_ok && next_ch[CH_W];
  always_ff @(posedge mclk_i) begin
    if (!rst_b_i) begin
      state_q <= ST_IDLE;
    end else if (launch) begin
      state_q <= ST_CONV;
    end else if (seq_end) begin
      state_q <= ST_IDLE;
    end
  end

  // channel under conversion; held after the sequence for the core's benefit
  always_ff @(posedge mclk_i) begin
    if (!rst_b_i) begin
      cur_q <= '0;
    end else if (launch) begin
      cur_q <= first_ch[CH_W-1:0];
    end else if (advance) begin
      cur_q <= next_ch[CH_W-1:0];
    end
  end

  // the core cannot be stopped, so a disable only marks its result for dropping
  always_ff @(posedge mclk_i) begin
    if (!rst_b_i) begin
      dead_q <= RST_BIT;
    end else if (launch || advance) begin
      dead_q <= RST_BIT;
    end else if (kill_cur) begin
      dead_q <= 1'b1;                                                      // [RULE11]
    end
  end

  // one start pulse per channel
  always_ff @(posedge mclk_i) begin
    if (!rst_b_i) begin
      core_start_o <= RST_BIT;
    end else begin
      core_start_o <= launch || advance;
    end
  end
  assign core_chan_o = cur_q;

  // sleep is only entered at the end of a sequence, never while idle
  always_ff @(posedge mclk_i) begin
    if (!rst_b_i) begin
      sleep_o <= RST_BIT;
    end else if (go || (wr_mode && !wdata_i[MODE_SLEEP_BIT])) begin
      sleep_o <= RST_BIT;
    end else if (seq_end && mode_sleep_q) begin
      sleep_o <= 1'b1;                                                     // [RULE13]
    end
  end

  // end flags; a set beside a clearing read keeps the flag, so no event is lost
  always_ff @(posedge mclk_i) begin
    if (!rst_b_i) begin
      eoc_q <= '0;                                                         // [RULE15]
    end else begin
      eoc_q <= eoc_d;
    end
  end

  // channel overrun flags
  always_ff @(posedge mclk_i) begin
    if (!rst_b_i) begin
      channel_overrun_flag_q <= '0;                                                        // [RULE15]
    end else begin
      channel_overrun_flag_q <= channel_overrun_flag_d;
    end
  end

  // result ready
  always_ff @(posedge mclk_i) begin
    if (!rst_b_i) begin
      result_ready_flag_q <= RST_BIT;                                                   // [RULE15]
    end else begin
      result_ready_flag_q <= result_ready_flag_d;
    end
  end

  // global overrun
  always_ff @(posedge mclk_i) begin
    if (!rst_b_i) begin
      global_overrun_flag_q <= RST_BIT;                                                  // [RULE15]
    end else begin
      global_overrun_flag_q <= global_overrun_flag_d;
    end
  end

  // last result; kept across reads so a late reader still sees it
  always_ff @(posedge mclk_i) begin
    if (!rst_b_i) begin
      last_res_q <= '0;
    end else if (store) begin
      last_res_q <= core_result_i;                                         // [RULE2]
    end
  end

  // channel of the last result, also picks the end flag a last read clears
  always_ff @(posedge mclk_i) begin
    if (!rst_b_i) begin
      last_ch_q <= '0;
    end else if (store) begin
      last_ch_q <= cur_q;
    end
  end

  // per-channel result words; a dropped result leaves the old word in place
  always_ff @(posedge mclk_i) begin
    if (!rst_b_i) begin
      for (int k = 0; k < NCH; k++) begin
        cdr_q[k] <= '0;
      end
    end else if (store) begin
      cdr_q[cur_q] <= core_result_i;                                       // [RULE2]
    end
  end

  // bus answer; zero outside its one-cycle slot
  always_ff @(posedge mclk_i) begin
    if (!rst_b_i) begin
      rdata_o <= RST_WORD;
    end else begin
      rdata_o <= rdata_d;
    end
  end

  // interrupt level, one cycle behind the flags
  always_ff @(posedge mclk_i) begin
    if (!rst_b_i) begin
      irq_o <= RST_BIT;
    end else begin
      irq_o <= irq_d;
    end
  end

endmodule : adc_status_flag_logic

// >>> verif/adc_status_flag_logic_sva.sv
// port-level checker for the converter status-flag block.
// assumes the register map and status layout of adc_flag_pkg; bound below.
`timescale 1ns/1ps
module adc_status_flag_logic_sva
  import adc_flag_pkg::*;
#(
  parameter int NCH   = NUM_CH_DEF,
  parameter int RES_W = RES_W_DEF,
  parameter int CH_W  = $clog2(NUM_CH_DEF)
) (
  // clock and reset
  input wire logic              mclk_i,
  input wire logic              rst_b_i,
  // register port
  input wire logic [ADDR_W-1:0] addr_i,
  input wire logic [DATA_W-1:0] wdata_i,
  input wire logic              wr_i,
  input wire logic              rd_i,
  input wire logic [DATA_W-1:0] rdata_o,
  input wire logic              irq_o,
  // analog core, pins and power
  input wire logic              core_start_o,
  input wire logic [CH_W-1:0]   core_chan_o,
  input wire logic              core_done_i,
  input wire logic [RES_W-1:0]  core_result_i,
  input wire logic              ext_trig_i,
  input wire logic              sleep_o
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_b_i);

  sequence rd_at(logic [ADDR_W-1:0] a);
    rd_i && addr_i == a;
  endsequence
  // quiet read: no conversion lands in that cycle, so only the read acts
  sequence quiet_rd(logic [ADDR_W-1:0] a);
    rd_at(a) ##0 !core_done_i;
  endsequence

  a_reset_quiet: assert property (disable iff (1'b0) !rst_b_i |=> rdata_o == RST_WORD
    && !irq_o && !core_start_o && !sleep_o) else $error("outputs not quiet after reset");
  a_rdata_slot: assert property (!rd_i |=> rdata_o == RST_WORD)
    else $error("read data outside its slot");
  a_start_single: assert property (core_start_o |=> !core_start_o)
    else $error("start pulse longer than one cycle");
  a_last_clears_ready: assert property (quiet_rd(OFS_LAST) ##1 rd_at(OFS_STATUS)
    |=> !rdata_o[STAT_RESULT_READY_FLAG_BIT]) else $error("ready survived last read");
  a_cdr_keeps_ready: assert property (rd_at(OFS_STATUS) ##1 (rd_at(OFS_CDR0) ##0
    rdata_o[STAT_RESULT_READY_FLAG_BIT]) ##1 rd_at(OFS_STATUS) |=> rdata_o[STAT_RESULT_READY_FLAG_BIT])
    else $error("channel read cleared ready");
  a_status_clears_ovr: assert property (quiet_rd(OFS_STATUS)
    ##1 rd_at(OFS_STATUS) |=> !rdata_o[STAT_GLOBAL_OVERRUN_FLAG_BIT]
    && rdata_o[STAT_CHANNEL_OVERRUN_FLAG_LSB +: STAT_FIELD_W] == '0)
    else $error("overrun survived status read");
  a_cdr_clears_own: assert property (quiet_rd(OFS_CDR0) ##1 rd_at(OFS_STATUS)
    |=> !rdata_o[STAT_EOC_LSB]) else $error("end flag survived its read");
  a_cdr_keeps_other: assert property (rd_at(OFS_STATUS) ##1 (rd_at(OFS_CDR0) ##0
    rdata_o[STAT_EOC_LSB+1]) ##1 rd_at(OFS_STATUS) |=> rdata_o[STAT_EOC_LSB+1])
    else $error("read cleared another end flag");
  a_sleep_after_done: assert property ($rose(sleep_o) |-> $past(core_done_i))
    else $error("sleep entered without a finished conversion");
endmodule : adc_status_flag_logic_sva

bind adc_status_flag_logic adc_status_flag_logic_sva #(.NCH(NCH), .RES_W(RES_W), .CH_W(CH_W))
  u_sva (.mclk_i(mclk_i), .rst_b_i(rst_b_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
  .rd_i(rd_i), .rdata_o(rdata_o), .irq_o(irq_o), .core_start_o(core_start_o),
  .core_chan_o(core_chan_o), .core_done_i(core_done_i), .core_result_i(core_result_i),
  .ext_trig_i(ext_trig_i), .sleep_o(sleep_o));

// >>> verif/adc_status_flag_logic_tb_top.sv
// self-checking bench for the converter status-flag block.
// assumes the bench plays both the register master and the analog core.
`timescale 1ns/1ps
module adc_status_flag_logic_tb_top;
  import adc_flag_pkg::*;
  logic              mclk_i = 1'b0;
  logic              rst_b_i = 1'b0;
  logic [ADDR_W-1:0] addr_i = '0;
  logic [DATA_W-1:0] wdata_i = '0;
  logic              wr_i = 1'b0;
  logic              rd_i = 1'b0;
  logic              core_done_i = 1'b0;
  logic              ext_trig_i = 1'b0;
  logic [9:0]        core_result_i = '0;
  logic [9:0]        res_v = '0;
  logic [DATA_W-1:0] rdata_o;
  logic              irq_o, core_start_o, sleep_o;
  logic              rd_d = 1'b0;
  logic [2:0]        core_chan_o;
  logic [31:0]       got[$];
  int                fail_count = 0;
  int                tests_run = 0;

  adc_status_flag_logic dut_u (.mclk_i(mclk_i), .rst_b_i(rst_b_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .irq_o(irq_o),
    .core_start_o(core_start_o), .core_chan_o(core_chan_o), .core_done_i(core_done_i),
    .core_result_i(core_result_i), .ext_trig_i(ext_trig_i), .sleep_o(sleep_o));

  initial forever #2 mclk_i = ~mclk_i;
  always @(posedge mclk_i) rd_d <= rd_i;
  // a reply stands one cycle only, so catch it mid-cycle
  always @(negedge mclk_i) if (rd_d) got.push_back(rdata_o);

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  // one bus cycle, optionally with a conversion ending in it
  task automatic acc(input logic r, w, input logic [7:0] a, input logic [31:0] d, input logic dn);
    {rd_i, wr_i, addr_i, wdata_i, core_done_i, core_result_i} <= {r, w, a, d, dn, res_v};
    @(posedge mclk_i);
  endtask : acc
  task automatic idle(input int n);
    repeat (n) acc(0, 0, 8'h00, '0, 0);
  endtask : idle
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    acc(0, 1, a, d, 0);
  endtask : wr
  task automatic rd(input logic [7:0] a);
    acc(1, 0, a, '0, 0);
  endtask : rd
  task automatic ex(input logic [31:0] e);
    chk("rdata", got.pop_front(), e);
  endtask : ex
  task automatic go;
    wr(OFS_CTRL, 32'h0000_0002);
    idle(2);
  endtask : go
  task automatic end_of_test;
    if (fail_count == 0 && tests_run > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : end_of_test

  initial begin
    repeat (2000) @(posedge mclk_i);
    fail_count++;
    end_of_test;
  end

  initial begin
    repeat (12) @(posedge mclk_i);
    rst_b_i <= 1'b1;
    idle(1);
    rd(OFS_STATUS); rd(OFS_LAST); rd(OFS_MASK); idle(1);
    ex('0); ex('0); ex('0);
    wr(OFS_MASK, 32'h0001_0000);
    wr(OFS_CHEN, 32'h0000_0003);
    res_v = 10'h155;
    go;
    acc(0, 0, 8'h00, '0, 1);
    res_v = 10'h2aa;
    idle(1);
    acc(1, 0, OFS_CDR0 + 8'h08, '0, 1);
    idle(2);
    chk("irq", {31'b0, irq_o}, 32'h1);
    rd(OFS_STATUS); rd(OFS_CDR0); rd(OFS_STATUS); rd(OFS_LAST); rd(OFS_STATUS); idle(2);
    ex('0);
    ex(32'h0003_0003);
    ex(32'h0000_0155);
    ex(32'h0001_0002);
    ex(32'h0000_12aa);
    ex('0);
    chk("irq", {31'b0, irq_o}, '0);
    // second pass on channel 0 alone, overrunning it
    wr(OFS_CHDIS, 32'h0000_0002);
    res_v = 10'h0aa;
    go; acc(0, 0, 8'h00, '0, 1); go; acc(0, 0, 8'h00, '0, 1);
    rd(OFS_CDR0); go; acc(1, 0, OFS_STATUS, '0, 1);
    rd(OFS_STATUS); rd(OFS_STATUS); rd(OFS_LAST); rd(OFS_STATUS); idle(1);
    ex(32'h0000_00aa);
    ex(32'h0003_0100);
    ex(32'h0003_0001);
    ex(32'h0001_0001);
    ex(32'h0000_00aa);
    ex('0);
    // channel dropped mid-conversion, done beside a last-result read
    wr(OFS_CTRL, 32'h0000_0002);
    wr(OFS_CHDIS, 32'h0000_0001);
    idle(1);
    acc(1, 0, OFS_LAST, '0, 1);
    rd(OFS_STATUS); rd(OFS_CHSR); idle(1);
    ex(32'h0000_00aa); ex('0); ex('0);
    wr(OFS_MODE, 32'h0000_0020);
    idle(3);
    chk("sleep", {31'b0, sleep_o}, '0);
    wr(OFS_CHEN, 32'h0000_0001);
    go;
    acc(0, 0, 8'h00, '0, 1);
    idle(2);
    chk("sleep", {31'b0, sleep_o}, 32'h1);
    rd(8'h08); rd(OFS_MASK); rd(OFS_CHSR); idle(1);
    ex('0); ex(32'h0001_0000); ex(32'h0000_0001);
    // pin-started pass; the mode write also drops sleep
    wr(OFS_MODE, 32'h0000_0001);
    ext_trig_i <= 1'b1;
    idle(6);
    chk("sleep", {31'b0, sleep_o}, '0);
    acc(0, 0, 8'h00, '0, 1);
    rd(OFS_STATUS); idle(1);
    ex(32'h0003_0101);
    wr(OFS_MASK, '0);
    idle(2);
    chk("irq", {31'b0, irq_o}, '0);
    end_of_test;
  end
endmodule : adc_status_flag_logic_tb_top
